/* File: rtl/mtas_defs.svh */
`ifndef MTAS_DEFS_SVH
`define MTAS_DEFS_SVH
`define MTAS_CLK_NS     5
`define MTAS_UNIT1_NS   1000
`define MTAS_UNIT2_NS   1000000
`define MTAS_UNIT3_NS   1000000000
`define MTAS_UNIT_OFF   2'h0
`define MTAS_UNIT_1     2'h1
`define MTAS_UNIT_2     2'h2
`define MTAS_CLS_N      4
`define MTAS_FLG_N      4
`define MTAS_FLG_BEGUN  0
`define MTAS_FLG_DONE   1
`define MTAS_FLG_INCR   2
`define MTAS_FLG_PURGE  3
`define MTAS_IRQ_N      4
`define MTAS_IRQ_RULE   0
`define MTAS_IRQ_PORTQ  1
`define MTAS_IRQ_DOMQ   2
`define MTAS_IRQ_OPDONE 3
`endif

/* File: rtl/mtas_pkg.sv */
package mtas_pkg;
  typedef enum logic [0:0] {st_idle, st_scan} mtas_state_e;
  typedef logic [1:0] mtas_cls_t;
  typedef logic [1:0] mtas_unit_t;
endpackage

/* File: rtl/mtas_tick_timer.sv */
`timescale 1ns/10ps
`include "mtas_defs.svh"
module mtas_tick_timer
  import mtas_pkg::*;
#(
  parameter int PER_W  = 16,
  parameter int U1_CYC = 200,
  parameter int U2_CYC = 200000,
  parameter int U3_CYC = 200000000
)
(
  input  wire logic             clk,      // clock
  input  wire logic             rstn,     // async reset, low
  input  wire logic             ce,       // clock enable
  input  wire logic             run,      // not paused, not halted
  input  wire mtas_unit_t       unit_sel, // tick unit, 0 = off
  input  wire logic [PER_W-1:0] period,   // ticks between scans
  output logic                  fire      // one-cycle scan request
);
  logic [31:0]      pre_ff;
  logic [31:0]      nxt_pre;
  logic [PER_W-1:0] per_ff;
  logic [PER_W-1:0] nxt_per;
  logic             fire_ff;
  logic             nxt_fire;

  wire [31:0]  unit_lim = (unit_sel == `MTAS_UNIT_1) ? 32'(U1_CYC - 1) :
                          (unit_sel == `MTAS_UNIT_2) ? 32'(U2_CYC - 1) : 32'(U3_CYC - 1);
  wire         active   = run && (unit_sel != `MTAS_UNIT_OFF);
  wire         tick     = active && (pre_ff >= unit_lim);
  wire [PER_W:0] per_inc = {1'h0, per_ff} + (PER_W + 1)'(1);
  // period of zero behaves as one tick
  wire         per_end  = per_inc >= {1'h0, period};

  assign nxt_pre  = (!active || tick) ? '0 : pre_ff + 32'h1;
  assign nxt_per  = !active ? '0 : (tick ? (per_end ? '0 : per_inc[PER_W-1:0]) : per_ff);
  assign nxt_fire = tick && per_end;
  assign fire     = fire_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_ff  <= '0;
      per_ff  <= '0;
      fire_ff <= 1'h0;
    end
    else if (ce)
    begin
      pre_ff  <= nxt_pre;
      per_ff  <= nxt_per;
      fire_ff <= nxt_fire;
    end
  end

  a_off_no_fire: assert property (@(posedge clk) disable iff (!rstn)
    ce && !active |=> !fire) else $error("timer fired while stopped");
endmodule

/* File: rtl/mtas_irq_collect.sv */
`timescale 1ns/10ps
module mtas_irq_collect
#(
  parameter int N = 4
)
(
  input  wire logic         clk,     // clock
  input  wire logic         rstn,    // async reset, low
  input  wire logic         ce,      // clock enable
  input  wire logic [N-1:0] src_ev,  // source event pulses
  input  wire logic [N-1:0] mask,    // per-source enable
  input  wire logic [N-1:0] clr,     // write-one-to-clear
  output logic      [N-1:0] pending, // sticky source status
  output logic      [N-1:0] active,  // enabled pending sources
  output logic              irq      // processor interrupt
);
  logic [N-1:0] pend_ff;
  logic [N-1:0] nxt_pend;

  assign nxt_pend = src_ev | (pend_ff & ~clr);
  assign pending  = pend_ff;
  assign active   = pend_ff & mask;
  assign irq      = |active;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pend_ff <= '0;
    else if (ce)
      pend_ff <= nxt_pend;
  end

  a_event_latched: assert property (@(posedge clk) disable iff (!rstn)
    ce && |src_ev |=> (pending & $past(src_ev)) == $past(src_ev)) else $error("event lost");
  a_hold_until_clr: assert property (@(posedge clk) disable iff (!rstn)
    ce && |(pending & ~clr) |=> (pending & $past(pending & ~clr)) == $past(pending & ~clr))
    else $error("sticky bit dropped without clear");
endmodule

/* File: rtl/mtas_age_scan.sv */
`timescale 1ns/10ps
`include "mtas_defs.svh"
module mtas_age_scan
  import mtas_pkg::*;
#(
  parameter int ROWS   = 16,
  parameter int VLANS  = 16,
  parameter int PORTS  = 8,
  parameter int AGE_W  = 2,
  parameter int PER_W  = 16,
  parameter int U1_CYC = `MTAS_UNIT1_NS / `MTAS_CLK_NS,
  parameter int U2_CYC = `MTAS_UNIT2_NS / `MTAS_CLK_NS,
  parameter int U3_CYC = `MTAS_UNIT3_NS / `MTAS_CLK_NS
)
(
  input  wire logic                           clk,                     // clock
  input  wire logic                           rstn,                    // async reset, low
  input  wire logic                           ce,                      // clock enable
  input  wire logic [AGE_W-1:0]               age_max,                 // maximum age count
  input  wire logic [2*`MTAS_CLS_N-1:0]       age_unit_sel,            // tick unit per class
  input  wire logic [PER_W*`MTAS_CLS_N-1:0]   age_tick_period,         // ticks per class
  input  wire logic                           age_pause,               // suspend auto aging
  input  wire logic                           scan_kick,               // start scan pulse
  input  wire logic                           scan_abort,              // stop scan pulse
  input  wire logic                           scan_graceful_halt,      // idle after scan
  input  wire logic [PORTS-1:0]               local_port_age_filter,   // ports that age
  input  wire logic                           remote_entry_age_filter, // remote entries age
  input  wire logic                           port_filter_apply,       // use port filters
  input  wire mtas_cls_t                      learn_age_class,         // class for learning
  input  wire logic                           vlan_fid_we,             // vlan fid write
  input  wire logic [$clog2(VLANS)-1:0]       vlan_fid_idx,            // vlan to write
  input  wire logic [$clog2(VLANS)-1:0]       vlan_fid_val,            // fid value
  input  wire logic                           src_req,                 // source lookup pulse
  input  wire logic [47:0]                    src_mac,                 // source mac
  input  wire logic [$clog2(VLANS)-1:0]       src_vid,                 // frame vlan
  input  wire logic                           src_mcast,               // multicast entry key
  input  wire logic [$clog2(PORTS)-1:0]       src_port,                // ingress port
  input  wire logic                           src_remote,              // learned remotely
  input  wire logic                           src_learn,               // learn on miss
  input  wire logic                           src_pin,                 // new entry pinned
  output logic                                src_hit,                 // lookup hit
  output logic [$clog2(ROWS)-1:0]             src_row,                 // hit or learned row
  output logic                                src_learned,             // entry created
  output logic [$clog2(ROWS)-1:0]             next_row,                // next row to scan
  output logic                                scan_active_flag,        // scan in progress
  output logic                                scan_begun_flag,         // sticky scan start
  output logic                                scan_done_flag,          // sticky scan end
  output logic                                entry_incremented_flag,  // sticky age bump
  output logic                                entry_purged_flag,       // sticky removal
  input  wire logic [`MTAS_FLG_N-1:0]         flag_clr,                // w1c for flags
  input  wire logic                           rule_match,              // classifier hit
  input  wire logic                           rule_irq_act,            // action wants irq
  input  wire logic                           port_quota_try,          // port limit overrun
  input  wire logic [$clog2(PORTS)-1:0]       port_quota_port,         // offending port
  input  wire logic [PORTS-1:0]               port_quota_ena,          // per-port enable
  input  wire logic                           domain_quota_try,        // fid limit overrun
  input  wire logic [$clog2(VLANS)-1:0]       domain_quota_id,         // offending fid
  input  wire logic [VLANS-1:0]               domain_quota_ena,        // per-fid enable
  input  wire logic                           table_op_done_ena,       // op-done source on
  input  wire logic [`MTAS_IRQ_N-1:0]         irq_mask,                // source enables
  input  wire logic [`MTAS_IRQ_N-1:0]         irq_clr,                 // w1c for sources
  output logic [`MTAS_IRQ_N-1:0]              irq_pending,             // sticky sources
  output logic [`MTAS_IRQ_N-1:0]              irq_active,              // enabled sources
  output logic                                irq                      // interrupt out
);
  localparam int RW = $clog2(ROWS);
  localparam int VW = $clog2(VLANS);
  localparam int PW = $clog2(PORTS);

  function automatic logic [RW:0] first_of(input logic [ROWS-1:0] v);
    logic [RW:0] r;
    r = '0;
    for (int i = ROWS - 1; i >= 0; i--)
      if (v[i])
        r = {1'h1, RW'(i)};
    return r;
  endfunction

  function automatic logic sticky(input logic q, input logic set, input logic clr);
    return set | (q & ~clr);
  endfunction

  logic             e_vld_ff  [ROWS];
  logic             e_pin_ff  [ROWS];
  logic             e_mc_ff   [ROWS];
  logic             e_rem_ff  [ROWS];
  logic [47:0]      e_mac_ff  [ROWS];
  logic [VW-1:0]    e_id_ff   [ROWS];
  logic [AGE_W-1:0] e_age_ff  [ROWS];
  mtas_cls_t        e_cls_ff  [ROWS];
  logic [PW-1:0]    e_port_ff [ROWS];
  logic [VW-1:0]    vlan_fid_ff [VLANS];

  mtas_state_e             state_ff;
  mtas_state_e             nxt_state;
  logic [RW-1:0]           row_ff;
  logic [RW-1:0]           nxt_row;
  mtas_cls_t               cls_ff;
  mtas_cls_t               nxt_cls;
  logic                    all_ff;
  logic                    nxt_all;
  logic [`MTAS_CLS_N-1:0]  req_ff;
  logic [`MTAS_CLS_N-1:0]  nxt_req;
  logic [`MTAS_CLS_N-1:0]  fire_v;
  mtas_cls_t               pick_cls;
  logic [`MTAS_FLG_N-1:0]  flg_ff;
  logic [`MTAS_FLG_N-1:0]  nxt_flg;
  logic [`MTAS_FLG_N-1:0]  flg_set;
  logic                    src_hit_ff;
  logic [RW-1:0]           src_row_ff;
  logic                    src_lrn_ff;
  logic [ROWS-1:0]         match_v;
  logic [ROWS-1:0]         free_v;
  logic [`MTAS_IRQ_N-1:0]  irq_ev;

  // multicast keys on the vlan itself so it is never shared
  wire [VW-1:0] src_id = src_mcast ? src_vid : vlan_fid_ff[src_vid];

  always_comb
  begin
    match_v = '0;
    free_v  = '0;
    for (int i = 0; i < ROWS; i++)
    begin
      match_v[i] = e_vld_ff[i] && (e_mac_ff[i] == src_mac) && (e_id_ff[i] == src_id)
                   && (e_mc_ff[i] == src_mcast);
      free_v[i]  = !e_vld_ff[i];
    end
  end

  wire [RW:0]   hit_f    = first_of(match_v);
  wire [RW:0]   free_f   = first_of(free_v);
  wire          hit_now  = src_req && hit_f[RW];
  wire [RW-1:0] hit_row  = hit_f[RW-1:0];
  wire          do_learn = src_req && !hit_f[RW] && src_learn && free_f[RW];
  wire [RW-1:0] free_row = free_f[RW-1:0];

  // class timers run only while aging is neither paused nor halted
  wire timer_run = !age_pause && !scan_graceful_halt;

  genvar c;
  generate
    for (c = 0; c < `MTAS_CLS_N; c++)
    begin : g_cls
      mtas_tick_timer #(
        .PER_W  (PER_W),
        .U1_CYC (U1_CYC),
        .U2_CYC (U2_CYC),
        .U3_CYC (U3_CYC)
      ) u_timer (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .run      (timer_run),
        .unit_sel (age_unit_sel[2*c +: 2]),
        .period   (age_tick_period[PER_W*c +: PER_W]),
        .fire     (fire_v[c])
      );
    end
  endgenerate

  always_comb
  begin
    pick_cls = '0;
    for (int k = `MTAS_CLS_N - 1; k >= 0; k--)
      if (req_ff[k])
        pick_cls = mtas_cls_t'(k);
  end

  wire scanning = (state_ff == st_scan);
  wire auto_ok  = !age_pause && !scan_graceful_halt && (|req_ff);
  wire start    = !scanning && (scan_kick || auto_ok);
  // kicked scans visit every class and ignore pause; pause stalls periodic scans in place
  wire stall    = age_pause && !all_ff;
  wire step     = scanning && !scan_abort && !stall;
  wire last     = (row_ff == RW'(ROWS - 1));
  wire finish   = step && last;

  wire filt_ok  = !port_filter_apply || (e_rem_ff[row_ff] ? remote_entry_age_filter
                                         : local_port_age_filter[e_port_ff[row_ff]]);
  // a same-cycle source hit proves activity, so the scan leaves that row alone
  wire row_hit  = hit_now && (hit_row == row_ff);
  wire cand     = step && e_vld_ff[row_ff] && !e_pin_ff[row_ff]
                  && (all_ff || e_cls_ff[row_ff] == cls_ff) && filt_ok && !row_hit;
  // above maximum also purges: protects against age_max lowered mid-life
  wire at_max   = e_age_ff[row_ff] >= age_max;
  wire purge    = cand && at_max;
  wire bump     = cand && !at_max;

  wire [`MTAS_CLS_N-1:0] req_take = (start && !scan_kick) ? ((`MTAS_CLS_N)'(1) << pick_cls) : '0;
  assign nxt_req = fire_v | (req_ff & ~req_take);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_row   = row_ff;
    nxt_cls   = cls_ff;
    nxt_all   = all_ff;
    case (state_ff)
      st_idle:
        if (start)
        begin
          nxt_state = st_scan;
          nxt_row   = '0;
          nxt_all   = scan_kick;
          nxt_cls   = pick_cls;
        end
      st_scan:
        if (scan_abort)
          nxt_state = st_idle;
        else if (step)
        begin
          nxt_row = RW'(row_ff + 1'h1);
          if (last)
            nxt_state = st_idle;
        end
      default:
        nxt_state = st_idle;
    endcase
  end

  always_comb
  begin
    flg_set                  = '0;
    flg_set[`MTAS_FLG_BEGUN] = start;
    flg_set[`MTAS_FLG_DONE]  = finish;
    flg_set[`MTAS_FLG_INCR]  = bump;
    flg_set[`MTAS_FLG_PURGE] = purge;
    for (int f = 0; f < `MTAS_FLG_N; f++)
      nxt_flg[f] = sticky(flg_ff[f], flg_set[f], flag_clr[f]);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff   <= st_idle;
      row_ff     <= '0;
      cls_ff     <= '0;
      all_ff     <= 1'h0;
      req_ff     <= '0;
      flg_ff     <= '0;
      src_hit_ff <= 1'h0;
      src_row_ff <= '0;
      src_lrn_ff <= 1'h0;
    end
    else if (ce)
    begin
      state_ff   <= nxt_state;
      row_ff     <= nxt_row;
      cls_ff     <= nxt_cls;
      all_ff     <= nxt_all;
      req_ff     <= nxt_req;
      flg_ff     <= nxt_flg;
      src_hit_ff <= hit_now;
      src_row_ff <= hit_now ? hit_row : free_row;
      src_lrn_ff <= do_learn;
    end
  end

  // vlans start out independent: each vlan maps to its own fid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      for (int v = 0; v < VLANS; v++)
        vlan_fid_ff[v] <= VW'(v);
    else if (ce && vlan_fid_we)
      vlan_fid_ff[vlan_fid_idx] <= vlan_fid_val;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      for (int i = 0; i < ROWS; i++)
      begin
        e_vld_ff[i]  <= 1'h0;
        e_pin_ff[i]  <= 1'h0;
        e_mc_ff[i]   <= 1'h0;
        e_rem_ff[i]  <= 1'h0;
        e_mac_ff[i]  <= '0;
        e_id_ff[i]   <= '0;
        e_age_ff[i]  <= '0;
        e_cls_ff[i]  <= '0;
        e_port_ff[i] <= '0;
      end
    else if (ce)
    begin
      if (do_learn)
      begin
        e_vld_ff[free_row]  <= 1'h1;
        e_pin_ff[free_row]  <= src_pin;
        e_mc_ff[free_row]   <= src_mcast;
        e_rem_ff[free_row]  <= src_remote;
        e_mac_ff[free_row]  <= src_mac;
        e_id_ff[free_row]   <= src_id;
        e_age_ff[free_row]  <= '0;
        e_cls_ff[free_row]  <= learn_age_class;
        e_port_ff[free_row] <= src_port;
      end
      if (hit_now)
        e_age_ff[hit_row] <= '0;
      if (bump)
        e_age_ff[row_ff] <= AGE_W'(e_age_ff[row_ff] + 1'h1);
      if (purge)
        e_vld_ff[row_ff] <= 1'h0;
    end
  end

  always_comb
  begin
    irq_ev                  = '0;
    irq_ev[`MTAS_IRQ_RULE]  = rule_match && rule_irq_act;
    irq_ev[`MTAS_IRQ_PORTQ] = port_quota_try && port_quota_ena[port_quota_port];
    irq_ev[`MTAS_IRQ_DOMQ]  = domain_quota_try && domain_quota_ena[domain_quota_id];
    irq_ev[`MTAS_IRQ_OPDONE] = table_op_done_ena && (finish || do_learn);
  end

  mtas_irq_collect #(
    .N (`MTAS_IRQ_N)
  ) u_irq (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .src_ev  (irq_ev),
    .mask    (irq_mask),
    .clr     (irq_clr),
    .pending (irq_pending),
    .active  (irq_active),
    .irq     (irq)
  );

  assign src_hit                = src_hit_ff;
  assign src_row                = src_row_ff;
  assign src_learned            = src_lrn_ff;
  assign next_row               = row_ff;
  assign scan_active_flag       = scanning;
  assign scan_begun_flag        = flg_ff[`MTAS_FLG_BEGUN];
  assign scan_done_flag         = flg_ff[`MTAS_FLG_DONE];
  assign entry_incremented_flag = flg_ff[`MTAS_FLG_INCR];
  assign entry_purged_flag      = flg_ff[`MTAS_FLG_PURGE];

  logic             chk_cand_ff;
  logic             chk_max_ff;
  logic             chk_pin_ff;
  logic [RW-1:0]    chk_row_ff;
  logic [AGE_W-1:0] chk_age_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chk_cand_ff <= 1'h0;
      chk_max_ff  <= 1'h0;
      chk_pin_ff  <= 1'h0;
      chk_row_ff  <= '0;
      chk_age_ff  <= '0;
    end
    else
    begin
      chk_cand_ff <= ce && cand;
      chk_max_ff  <= at_max;
      chk_pin_ff  <= ce && step && e_vld_ff[row_ff] && e_pin_ff[row_ff] && !row_hit;
      chk_row_ff  <= row_ff;
      chk_age_ff  <= e_age_ff[row_ff];
    end
  end

  a_pinned_untouched: assert property (@(posedge clk) disable iff (!rstn)
    chk_pin_ff |-> e_vld_ff[chk_row_ff] && e_age_ff[chk_row_ff] == chk_age_ff)
    else $error("pinned entry changed by scan");
  a_max_removes: assert property (@(posedge clk) disable iff (!rstn)
    chk_cand_ff && chk_max_ff |-> !e_vld_ff[chk_row_ff] && entry_purged_flag)
    else $error("entry at maximum age not removed");
  a_below_max_bumps: assert property (@(posedge clk) disable iff (!rstn)
    chk_cand_ff && !chk_max_ff |-> e_vld_ff[chk_row_ff] && e_age_ff[chk_row_ff] == AGE_W'(chk_age_ff + 1'h1)
    && entry_incremented_flag) else $error("age not incremented by one");
  a_hit_clears_age: assert property (@(posedge clk) disable iff (!rstn)
    src_hit |-> e_age_ff[src_row] == '0) else $error("source hit left age nonzero");
  a_kick_starts: assert property (@(posedge clk) disable iff (!rstn)
    ce && !scanning && scan_kick |=> scan_active_flag && next_row == '0 && scan_begun_flag)
    else $error("kick did not start a scan");
  a_abort_stops: assert property (@(posedge clk) disable iff (!rstn)
    ce && scanning && scan_abort |=> !scan_active_flag) else $error("abort did not stop scan");
  a_halt_stays_idle: assert property (@(posedge clk) disable iff (!rstn)
    ce && !scanning && scan_graceful_halt && !scan_kick |=> !scan_active_flag)
    else $error("periodic scan started under halt");
  a_last_row_done: assert property (@(posedge clk) disable iff (!rstn)
    ce && finish |=> !scan_active_flag && scan_done_flag && next_row == '0)
    else $error("scan end not reported");
  a_pause_freezes_row: assert property (@(posedge clk) disable iff (!rstn)
    ce && scanning && !all_ff && age_pause && !scan_abort |=> scan_active_flag && $stable(next_row))
    else $error("paused scan advanced");

  c_entry_purged: cover property (@(posedge clk) disable iff (!rstn) purge);
  c_scan_done: cover property (@(posedge clk) disable iff (!rstn) ce && finish && !all_ff);
  c_kick_scan: cover property (@(posedge clk) disable iff (!rstn) ce && !scanning && scan_kick);
  c_learn_then_hit: cover property (@(posedge clk) disable iff (!rstn) src_learned ##[1:20] src_hit);
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import mtas_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, ce = 1'h1, age_pause = 1'h0, scan_kick = 1'h0, scan_abort = 1'h0;
  logic        scan_graceful_halt = 1'h0, remote_entry_age_filter = 1'h0, port_filter_apply = 1'h0;
  logic        vlan_fid_we = 1'h0, src_req = 1'h0, src_mcast = 1'h0, src_remote = 1'h0, src_learn = 1'h0;
  logic        src_pin = 1'h0, rule_match = 1'h0, rule_irq_act = 1'h0, port_quota_try = 1'h0;
  logic        domain_quota_try = 1'h0, table_op_done_ena = 1'h0;
  logic [1:0]  age_max = 2'h1;
  logic [7:0]  age_unit_sel = 8'h00, local_port_age_filter = 8'hFF, port_quota_ena = 8'hFF;
  logic [63:0] age_tick_period = '0;
  logic [3:0]  vlan_fid_idx = '0, vlan_fid_val = '0, src_vid = '0, domain_quota_id = '0;
  logic [3:0]  flag_clr = '0, irq_mask = '0, irq_clr = '0;
  logic [47:0] src_mac = '0;
  logic [2:0]  src_port = '0, port_quota_port = '0;
  logic [15:0] domain_quota_ena = '0;
  mtas_cls_t   learn_age_class = 2'h0;
  logic        src_hit, src_learned, scan_active_flag, scan_begun_flag, scan_done_flag, irq;
  logic        entry_incremented_flag, entry_purged_flag;
  logic [3:0]  src_row, next_row, irq_pending, irq_active;
  int          errors = 0, samples_checked = 0, i;
  // short tick units keep periodic scans within a few dozen cycles
  mtas_age_scan #(.U1_CYC(2), .U2_CYC(3), .U3_CYC(4)) mtas_age_scan_i (.*);
  always #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic look(input logic [47:0] m, input logic [3:0] v, input logic mc, learn_unit, pin, ex_hit);
    @(negedge clk);
    {src_req, src_mac, src_vid, src_mcast, src_learn, src_pin} = {1'h1, m, v, mc, learn_unit, pin};
    @(negedge clk);
    src_req = 1'h0;
    chk({src_hit, src_learned}, {ex_hit, learn_unit & !ex_hit});
  endtask
  task automatic clrflags();
    @(negedge clk) flag_clr = 4'hF;
    @(negedge clk) flag_clr = 4'h0;
  endtask
  // abort_after 0 runs the scan to its end and checks its length
  task automatic kick(input int abort_after);
    @(negedge clk) scan_kick = 1'h1;
    @(negedge clk) scan_kick = 1'h0;
    chk(scan_active_flag, 1'h1);
    if (abort_after > 0)
    begin
      repeat (abort_after) @(negedge clk);
      scan_abort = 1'h1;
      @(negedge clk) scan_abort = 1'h0;
    end
    for (i = 0; i < 40 && scan_active_flag; i++) @(negedge clk);
    chk(scan_active_flag, 1'h0);
    if (abort_after == 0) chk(i, 16);
  endtask
  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #10000;
    errors++;
    final_report();
  end
  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'h1;
    chk({scan_begun_flag, scan_done_flag, next_row, irq_pending}, '0);
    look(48'hA, 4'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    look(48'hB, 4'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    look(48'hC, 4'h3, 1'h0, 1'h1, 1'h1, 1'h0);
    @(negedge clk) {vlan_fid_we, vlan_fid_idx, vlan_fid_val} = {1'h1, 4'h2, 4'h1};
    @(negedge clk) vlan_fid_we = 1'h0;
    look(48'hA, 4'h2, 1'h0, 1'h0, 1'h0, 1'h1);
    look(48'hB, 4'h2, 1'h1, 1'h0, 1'h0, 1'h0);
    kick(0);
    chk({scan_begun_flag, scan_done_flag, entry_incremented_flag, entry_purged_flag}, 4'hE);
    look(48'hA, 4'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    clrflags();
    kick(0);
    chk({scan_begun_flag, scan_done_flag, entry_incremented_flag, entry_purged_flag}, 4'hF);
    look(48'hB, 4'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    look(48'hA, 4'h1, 1'h0, 1'h0, 1'h0, 1'h1);
    look(48'hC, 4'h3, 1'h0, 1'h0, 1'h0, 1'h1);
    clrflags();
    kick(3);
    chk(scan_done_flag, 1'h0);
    clrflags();
    age_tick_period[15:0] = 16'h0001;
    age_unit_sel = 8'h01;
    for (i = 0; i < 60 && !scan_begun_flag; i++) @(negedge clk);
    chk(scan_begun_flag, 1'h1);
    age_pause = 1'h1;
    clrflags();
    repeat (40) @(negedge clk);
    chk({scan_begun_flag, scan_done_flag}, 2'h0);
    age_unit_sel = 8'h00;
    age_pause = 1'h0;
    for (i = 0; i < 40 && !scan_done_flag; i++) @(negedge clk);
    chk(scan_done_flag, 1'h1);
    // halt lets any running scan end, then no periodic scan may start
    scan_graceful_halt = 1'h1;
    age_unit_sel = 8'h01;
    repeat (20) @(negedge clk);
    clrflags();
    repeat (40) @(negedge clk);
    chk({scan_begun_flag, scan_done_flag, scan_active_flag}, 3'h0);
    // filters applied with nothing selected: scan runs but ages nothing
    age_unit_sel = 8'h00;
    port_filter_apply = 1'h1;
    local_port_age_filter = 8'h00;
    table_op_done_ena = 1'h1;
    kick(0);
    chk({scan_begun_flag, scan_done_flag, entry_incremented_flag, entry_purged_flag}, 4'hC);
    chk(irq_pending[3], 1'h1);
    table_op_done_ena = 1'h0;
    port_filter_apply = 1'h0;
    local_port_age_filter = 8'hFF;
    scan_graceful_halt = 1'h0;
    @(negedge clk) irq_clr = 4'h8;
    @(negedge clk) irq_clr = 4'h0;
    chk(irq_pending, 4'h0);
    irq_mask = 4'h1;
    @(negedge clk) {rule_match, rule_irq_act} = 2'h3;
    @(negedge clk) {rule_match, rule_irq_act} = 2'h0;
    chk({irq_pending[0], irq}, 2'h3);
    @(negedge clk) {port_quota_try, port_quota_port, domain_quota_try} = {1'h1, 3'h2, 1'h1};
    @(negedge clk) {port_quota_try, domain_quota_try} = 2'h0;
    chk({irq_pending, irq_active}, 8'h31);
    @(negedge clk) irq_clr = 4'hF;
    @(negedge clk) irq_clr = 4'h0;
    chk({irq_pending, irq}, 5'h00);
    final_report();
  end
endmodule
